// ### rtl/power_seq_pkg.sv
// power_seq_pkg: constants shared by the power-up sequencer files
// assumes a single 100 MHz clock; all times are rounded to whole cycles here
package power_seq_pkg;

	// ***************************************************************
	// clock and timing
	// ***************************************************************
	localparam int unsigned CLK_PERIOD_NS = 10; // 100 MHz core clock
	localparam int unsigned TICK_TIME_NS = 1000000; // one millisecond time base
	localparam int unsigned TICK_CYC_DEF = TICK_TIME_NS / CLK_PERIOD_NS; // cycles per ms tick
	localparam int unsigned MGMT_READY_NS = 40000; // management bus ready time, longest
	localparam logic [11:0] MGMT_CYC = 12'(MGMT_READY_NS / CLK_PERIOD_NS); // rounds down
	localparam logic [11:0] MGMT_ZERO = 12'h000; // ready counter reset value
	localparam logic [7:0] MARGIN_MS = 8'h05; // fixed timeout margin, 5 ms

	// ***************************************************************
	// soft-start codes, in ms
	// ***************************************************************
	localparam logic [3:0] SS0_MS = 4'h1; // soft-start code 0
	localparam logic [3:0] SS1_MS = 4'h2; // soft-start code 1
	localparam logic [3:0] SS2_MS = 4'h4; // soft-start code 2
	localparam logic [3:0] SS3_MS = 4'h8; // soft-start code 3

	// ***************************************************************
	// register addresses and fields seen on the write port
	// ***************************************************************
	localparam logic [7:0] ADDR_STATUS = 8'h08; // status register
	localparam logic [7:0] STAT_RESET = 8'h00; // status value after reset
	localparam logic [7:0] STAT_DONE_MASK = 8'h2c; // bits 5,3,2 set on power-up done
	localparam logic [7:0] ADDR_HOST_LO = 8'h15; // first secured host register
	localparam logic [7:0] ADDR_MODE = 8'h2f; // operating-mode register, last secured host reg
	localparam int unsigned MODE_BIT = 2; // operating-mode bit position
	localparam logic [7:0] ADDR_VRCTL = 8'h32; // regulator enable control register
	localparam int unsigned VREN_BIT = 7; // regulator enable bit position
	localparam logic [7:0] VRCTL_OPEN = 8'h40; // only bit 6 stays writable when locked
	localparam logic [7:0] ADDR_VEND_LO = 8'h40; // first secured vendor register
	localparam logic [7:0] ADDR_VEND_HI = 8'h6f; // last secured vendor register
	localparam logic [7:0] MASK_ALL = 8'hff; // every bit writable
	localparam logic [7:0] MASK_NONE = 8'h00; // nothing writable

	// ***************************************************************
	// timer
	// ***************************************************************
	localparam int unsigned TMR_W = 20; // timer width, holds one ms in cycles
	localparam logic [TMR_W-1:0] TMR_ZERO = '0; // timer idle value
	localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001; // timer decrement

endpackage

// ### rtl/timer_if.sv
// timer_if: load/step/expire bundle between the sequencer and its timers
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
	import power_seq_pkg::*;
	logic load; // load a new count
	logic [TMR_W-1:0] load_val; // count to load
	logic step; // count one unit this cycle
	logic expire; // pulse on the last unit
	logic busy; // count is non-zero
	modport timer (input load, input load_val, input step, output expire, output busy);
	modport user (output load, output load_val, output step, input expire, input busy);
endinterface
`default_nettype wire

// ### rtl/down_timer.sv
// down_timer: loadable down counter that pulses expire on its last step
// assumes load and step come from logic on clk_in
`timescale 1ns/1ps
`default_nettype none
module down_timer
	import power_seq_pkg::*;
(
	input wire logic clk_in, // core clock
	input wire logic rst_b_in, // synchronous reset, active low
	timer_if.timer tmr // control and status bundle
);

	// ***************************************************************
	// counter
	// ***************************************************************
	logic [TMR_W-1:0] count; // remaining units
	logic [TMR_W-1:0] next_count; // next remaining units

	// load wins over stepping so a reload on expiry loses no cycle
	always_comb begin
		next_count = count;
		if (tmr.load) begin
			next_count = tmr.load_val;
		end else if (tmr.step && (count != TMR_ZERO)) begin
			next_count = count - TMR_ONE;
		end
	end

	// register only
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			count <= TMR_ZERO;
		end else begin
			count <= next_count;
		end
	end

	assign tmr.busy = (count != TMR_ZERO);
	assign tmr.expire = tmr.step && (count == TMR_ONE);

endmodule
`default_nettype wire

// ### rtl/pmic_power_up_sequencer.sv
// pmic_power_up_sequencer: power-up control of a memory-module power manager
// assumes rst_b_in is asserted only when the main input supply is removed,
// and the bus front end presents decoded writes on the clock
//
// Overview of operation
// - no action until main supply is valid
// - valid supply: power-ok low, aux LDOs on
// - bus ready after management time; host waits
// - enable pin high starts rails, no command
// - pin, 0x32 bit 7 or DEVCTRL enable
// - enable request first checks supply valid
// - load settings, run steps 0..2, start rails
// - done: set status bits, release power-ok
// - may NACK from enable until timeout
// - timeout: sum of softstart+delay plus margin
// - delay starts after longest soft-start in step
// - programmable mode: host writes never masked
// - secure mode after enable: block listed writes
// - secure lock cleared only by power cycle
// - mode resets 0; writes open before enable
`timescale 1ns/1ps
`default_nettype none
module pmic_power_up_sequencer
	import power_seq_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF // cycles per ms tick
)(
	input wire logic clk_in, // 100 MHz core clock
	input wire logic rst_b_in, // power-cycle reset, active low
	input wire logic main_input_supply_ok_in, // supply at or above 4.25 V, async
	input wire logic regulator_enable_pin_in, // enable pin, async
	input wire logic devctrl_enable_in, // bus enable common command, pulse
	input wire logic wr_valid_in, // host register write request
	input wire logic [7:0] wr_addr_in, // write address
	input wire logic [7:0] wr_data_in, // write data
	input wire logic [2:0][2:0] step_rails_in, // per step: rails c,b,a used
	input wire logic [2:0][1:0] softstart_code_in, // per rail soft-start code
	input wire logic [2:0][3:0] step_delay_ms_in, // per step delay, ms
	output logic power_ok_output_out, // pin level when driven, always low
	output logic power_ok_output_oe_out, // high while pulling the pin low
	output logic aux_ldo_high_en_out, // 1.8 V auxiliary output enable
	output logic aux_ldo_low_en_out, // 1.0 V auxiliary output enable
	output logic [2:0] buck_rail_en_out, // rails c,b,a enables
	output logic load_settings_out, // pulse: copy vendor settings inward
	output logic bus_ready_out, // management bus operational
	output logic bus_nack_out, // refuse bus requests now
	output logic wr_ack_out, // write taken this cycle
	output logic [7:0] wr_bit_mask_out, // bits the taken write may change
	output logic mode_secure_out, // operating-mode bit, 1 = secure
	output logic [7:0] status_out // status register image
);

	// ***************************************************************
	// input synchronisers
	// ***************************************************************
	logic supply_meta; // first stage, read only by supply_s
	logic supply_s; // synchronised supply valid
	logic pin_meta; // first stage, read only by pin_s
	logic pin_s; // synchronised enable pin

	// two flops on each pin input
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			supply_meta <= 1'b0;
			supply_s <= 1'b0;
			pin_meta <= 1'b0;
			pin_s <= 1'b0;
		end else begin
			supply_meta <= main_input_supply_ok_in;
			supply_s <= supply_meta;
			pin_meta <= regulator_enable_pin_in;
			pin_s <= pin_meta;
		end
	end

	// ***************************************************************
	// timers: ms tick divider, step timer, power-up timeout
	// ***************************************************************
	timer_if div_if(); // ms tick divider
	timer_if step_if(); // soft-start and delay timer
	timer_if tmo_if(); // power-up timeout
	logic ms_tick; // one-cycle pulse per ms

	down_timer u_div (.clk_in(clk_in), .rst_b_in(rst_b_in), .tmr(div_if.timer));
	down_timer u_step (.clk_in(clk_in), .rst_b_in(rst_b_in), .tmr(step_if.timer));
	down_timer u_tmo (.clk_in(clk_in), .rst_b_in(rst_b_in), .tmr(tmo_if.timer));

	// free-running divider reloads itself on expiry
	assign div_if.load = div_if.expire || !div_if.busy;
	assign div_if.load_val = TMR_W'(TICK_CYC);
	assign div_if.step = 1'b1;
	assign ms_tick = div_if.expire;
	assign step_if.step = ms_tick;
	assign tmo_if.step = ms_tick;

	// ***************************************************************
	// per-step soft-start maximum and timeout sum
	// ***************************************************************
	logic [2:0][3:0] step_ss; // longest soft-start of each step, ms
	logic [7:0] tmo_sum; // total timeout, ms

	function automatic logic [3:0] ss_ms(input logic [1:0] code);
		unique case (code)
			2'h0: return SS0_MS;
			2'h1: return SS1_MS;
			2'h2: return SS2_MS;
			2'h3: return SS3_MS;
		endcase
	endfunction

	// the delay waits for the slowest rail of the step
	always_comb begin
		tmo_sum = MARGIN_MS;
		for (int s = 0; s < 3; s++) begin
			step_ss[s] = 4'h0;
			for (int r = 0; r < 3; r++) begin
				if (step_rails_in[s][r] && (ss_ms(softstart_code_in[r]) > step_ss[s])) begin
					step_ss[s] = ss_ms(softstart_code_in[r]);
				end
			end
			if (step_rails_in[s] != 3'h0) begin
				tmo_sum = tmo_sum + {4'h0, step_ss[s]} + {4'h0, step_delay_ms_in[s]};
			end
		end
	end

	// ***************************************************************
	// management ready counter
	// ***************************************************************
	logic [11:0] ready_cnt; // cycles since supply became valid
	logic [11:0] next_ready_cnt; // next count
	logic supply_up; // supply seen valid, sticky

	// saturates at the ready time
	always_comb begin
		next_ready_cnt = ready_cnt;
		if (supply_up && (ready_cnt != MGMT_CYC)) begin
			next_ready_cnt = ready_cnt + 12'h001;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ready_cnt <= MGMT_ZERO;
		end else begin
			ready_cnt <= next_ready_cnt;
		end
	end

	assign bus_ready_out = (ready_cnt == MGMT_CYC);

	// ***************************************************************
	// sequencer state machine
	// ***************************************************************
	typedef enum logic [2:0] {S_OFF, S_IDLE, S_CHECK, S_LOAD, S_STEP, S_SOFT, S_DELAY, S_DONE} seq_state_e;
	seq_state_e state, next_state; // sequencer state
	logic [1:0] step_idx, next_step_idx; // current config step
	logic [2:0] rails, next_rails; // rail enables
	logic pg_oe, next_pg_oe; // power-ok pulled low
	logic ldo_on, next_ldo_on; // aux LDOs on
	logic load_p, next_load_p; // settings load pulse
	logic [7:0] status, next_status; // status image
	logic enable_seen, next_enable_seen; // enable request registered
	logic mode_sec, next_mode_sec; // operating-mode bit
	logic en_req; // any enable request this cycle
	logic bus_en; // enable written over the bus
	logic mode_wr; // mode bit written this cycle
	logic locked; // secure protection active

	assign supply_up = (state != S_OFF);
	assign locked = mode_sec && enable_seen;
	assign bus_nack_out = enable_seen && (state != S_DONE) && tmo_if.busy;
	assign wr_ack_out = wr_valid_in && bus_ready_out && !bus_nack_out;

	// write protection mask; open before enable and in programmable mode
	always_comb begin
		wr_bit_mask_out = MASK_ALL;
		if (locked) begin
			if ((wr_addr_in >= ADDR_HOST_LO) && (wr_addr_in <= ADDR_MODE)) begin
				wr_bit_mask_out = MASK_NONE;
			end else if ((wr_addr_in >= ADDR_VEND_LO) && (wr_addr_in <= ADDR_VEND_HI)) begin
				wr_bit_mask_out = MASK_NONE;
			end else if (wr_addr_in == ADDR_VRCTL) begin
				wr_bit_mask_out = VRCTL_OPEN;
			end
		end
	end

	assign bus_en = wr_ack_out && (wr_addr_in == ADDR_VRCTL) && wr_bit_mask_out[VREN_BIT] && wr_data_in[VREN_BIT];
	assign mode_wr = wr_ack_out && (wr_addr_in == ADDR_MODE) && wr_bit_mask_out[MODE_BIT];
	// level pin is safe because the host never drops it during the ramp
	assign en_req = pin_s || devctrl_enable_in || bus_en;

	// mode bit and the enable record; only the power-cycle reset clears the record, an unlocked write may clear the mode bit
	always_comb begin
		next_mode_sec = mode_sec;
		next_enable_seen = enable_seen;
		if (mode_wr) begin
			next_mode_sec = wr_data_in[MODE_BIT];
		end
		if ((state == S_IDLE) && en_req) begin
			next_enable_seen = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			mode_sec <= 1'b0;
			enable_seen <= 1'b0;
		end else begin
			mode_sec <= next_mode_sec;
			enable_seen <= next_enable_seen;
		end
	end

	// sequence: supply check, settings load, three steps, release
	always_comb begin
		next_state = state;
		next_step_idx = step_idx;
		next_rails = rails;
		next_pg_oe = pg_oe;
		next_ldo_on = ldo_on;
		next_load_p = 1'b0;
		next_status = status;
		step_if.load = 1'b0;
		step_if.load_val = TMR_ZERO;
		tmo_if.load = 1'b0;
		tmo_if.load_val = {{(TMR_W-8){1'b0}}, tmo_sum};
		unique case (state)
			S_OFF: begin
				if (supply_s) begin
					next_pg_oe = 1'b1;
					next_ldo_on = 1'b1;
					next_state = S_IDLE;
				end
			end
			S_IDLE: begin
				if (en_req) begin
					tmo_if.load = 1'b1;
					next_state = S_CHECK;
				end
			end
			S_CHECK: begin
				if (supply_s) begin
					next_load_p = 1'b1;
					next_step_idx = 2'h0;
					next_state = S_LOAD;
				end
			end
			S_LOAD: begin
				next_state = S_STEP;
			end
			S_STEP: begin
				if (step_rails_in[step_idx] == 3'h0) begin
					// empty step is skipped and adds nothing to the timeout
					next_state = (step_idx == 2'h2) ? S_DONE : S_STEP;
					next_step_idx = step_idx + 2'h1;
				end else begin
					next_rails = rails | step_rails_in[step_idx];
					step_if.load = 1'b1;
					step_if.load_val = {{(TMR_W-4){1'b0}}, step_ss[step_idx]};
					next_state = S_SOFT;
				end
			end
			S_SOFT: begin
				if (step_if.expire) begin
					if (step_delay_ms_in[step_idx] != 4'h0) begin
						step_if.load = 1'b1;
						step_if.load_val = {{(TMR_W-4){1'b0}}, step_delay_ms_in[step_idx]};
						next_state = S_DELAY;
					end else begin
						next_state = (step_idx == 2'h2) ? S_DONE : S_STEP;
						next_step_idx = step_idx + 2'h1;
					end
				end
			end
			S_DELAY: begin
				if (step_if.expire) begin
					next_state = (step_idx == 2'h2) ? S_DONE : S_STEP;
					next_step_idx = step_idx + 2'h1;
				end
			end
			S_DONE: begin
				next_status = status | STAT_DONE_MASK;
				next_pg_oe = 1'b0;
			end
		endcase
		if ((next_state == S_DONE) && (state != S_DONE)) begin
			// release and status land on the same edge
			next_status = status | STAT_DONE_MASK;
			next_pg_oe = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state <= S_OFF;
			step_idx <= 2'h0;
			rails <= 3'h0;
			pg_oe <= 1'b0;
			ldo_on <= 1'b0;
			load_p <= 1'b0;
			status <= STAT_RESET;
		end else begin
			state <= next_state;
			step_idx <= next_step_idx;
			rails <= next_rails;
			pg_oe <= next_pg_oe;
			ldo_on <= next_ldo_on;
			load_p <= next_load_p;
			status <= next_status;
		end
	end

	assign power_ok_output_out = 1'b0;
	assign power_ok_output_oe_out = pg_oe;
	assign aux_ldo_high_en_out = ldo_on;
	assign aux_ldo_low_en_out = ldo_on;
	assign buck_rail_en_out = rails;
	assign load_settings_out = load_p;
	assign mode_secure_out = mode_sec;
	assign status_out = status;

	// ***************************************************************
	// assertions
	// ***************************************************************
	property p_quiet_off;
		@(posedge clk_in) disable iff (!rst_b_in) (state == S_OFF) |-> (!power_ok_output_oe_out && !aux_ldo_high_en_out && buck_rail_en_out == 3'h0);
	endproperty
	a_quiet_off: assert property (p_quiet_off) else $error("activity before supply valid");

	property p_supply_up;
		@(posedge clk_in) disable iff (!rst_b_in) (state == S_OFF && supply_s) |=> (power_ok_output_oe_out && aux_ldo_high_en_out && aux_ldo_low_en_out);
	endproperty
	a_supply_up: assert property (p_supply_up) else $error("power-ok or LDOs missing after supply valid");

	property p_bus_ready;
		@(posedge clk_in) disable iff (!rst_b_in) $rose(bus_ready_out) |-> ($past(ready_cnt) == MGMT_CYC - 12'h001) && !$past(wr_ack_out);
	endproperty
	a_bus_ready: assert property (p_bus_ready) else $error("bus ready at wrong time");

	property p_pin_start;
		@(posedge clk_in) disable iff (!rst_b_in) (state == S_IDLE && pin_s) |=> (state == S_CHECK && enable_seen);
	endproperty
	a_pin_start: assert property (p_pin_start) else $error("enable pin not taken");

	property p_bus_enable;
		@(posedge clk_in) disable iff (!rst_b_in) (state == S_IDLE && wr_ack_out && wr_addr_in == ADDR_VRCTL && wr_data_in[VREN_BIT]) |=> enable_seen ##1 load_settings_out || state == S_CHECK;
	endproperty
	a_bus_enable: assert property (p_bus_enable) else $error("bus enable not taken");

	property p_check_supply;
		@(posedge clk_in) disable iff (!rst_b_in) (state == S_CHECK && !supply_s) |=> (state == S_CHECK && !load_settings_out);
	endproperty
	a_check_supply: assert property (p_check_supply) else $error("sequence ran without valid supply");

	property p_done;
		@(posedge clk_in) disable iff (!rst_b_in) $rose(state == S_DONE) |-> !power_ok_output_oe_out && ((status_out & STAT_DONE_MASK) == STAT_DONE_MASK) && $past(power_ok_output_oe_out);
	endproperty
	a_done: assert property (p_done) else $error("completion not reported");

	property p_softstart_max;
		@(posedge clk_in) disable iff (!rst_b_in) (state == S_STEP && step_rails_in[step_idx] != 3'h0) |=> (state == S_SOFT) && (u_step.count == {{(TMR_W-4){1'b0}}, $past(step_ss[step_idx])});
	endproperty
	a_softstart_max: assert property (p_softstart_max) else $error("step timer not loaded with longest soft-start");

	property p_secure_block;
		@(posedge clk_in) disable iff (!rst_b_in) (locked && wr_valid_in && wr_addr_in >= ADDR_HOST_LO && wr_addr_in <= ADDR_MODE) |-> (wr_bit_mask_out == MASK_NONE);
	endproperty
	a_secure_block: assert property (p_secure_block) else $error("secured register writable");

	property p_open_before;
		@(posedge clk_in) disable iff (!rst_b_in) (!enable_seen || !mode_secure_out) |-> (wr_bit_mask_out == MASK_ALL);
	endproperty
	a_open_before: assert property (p_open_before) else $error("write blocked while unlocked");

	property p_open_drain;
		@(posedge clk_in) disable iff (!rst_b_in) !power_ok_output_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("power-ok driven high");

	c_done: cover property (@(posedge clk_in) disable iff (!rst_b_in) $rose(state == S_DONE));
	c_secure: cover property (@(posedge clk_in) disable iff (!rst_b_in) locked && wr_ack_out && wr_bit_mask_out == MASK_NONE);
	c_bus_en: cover property (@(posedge clk_in) disable iff (!rst_b_in) state == S_IDLE && bus_en);
	c_nack: cover property (@(posedge clk_in) disable iff (!rst_b_in) bus_nack_out && wr_valid_in);

endmodule
`default_nettype wire

// ### sim/host_model.sv
// host_model: host side of the main supply ramp and the enable pin
// assumes the bench commands ramp and pin requests, all on clk_in
`timescale 1ns/1ps
`default_nettype none
module host_model #(
	parameter int unsigned HOLD_CYC = 8 // supply stable time before pin may rise
)(
	input wire logic clk_in, // core clock
	input wire logic ramp_in, // bench: main supply on
	input wire logic pin_early_in, // bench: pin high before the ramp
	input wire logic pin_req_in, // bench: ask for pin enable
	output logic supply_ok_out, // main supply valid level
	output logic pin_out // enable pin level
);
	// ***************************************************************
	// supply and pin
	// ***************************************************************
	int unsigned stable_cnt; // cycles since supply valid
	initial begin
		supply_ok_out = 1'b0;
		pin_out = 1'b0;
		stable_cnt = 0;
	end
	// the pin only falls with the supply, so it never drops in a ramp
	always @(negedge clk_in) begin
		supply_ok_out <= ramp_in;
		stable_cnt <= ramp_in ? stable_cnt + 1 : 0;
		if (!ramp_in) begin
			pin_out <= pin_early_in;
		end else if (pin_early_in || (pin_req_in && stable_cnt >= HOLD_CYC)) begin
			pin_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// tb_top: self-checking bench of the power-up sequencer
// assumes a shortened ms tick; the host model drives supply and pin
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import power_seq_pkg::*;
	localparam int TICK = 20; // short ms tick; signed so timing bounds below stay signed
	logic clk_in, rst_b_in, devctrl, wr_valid, ramp, pin_early, pin_req, sup_ok, pin;
	logic po, po_oe, ldo_h, ldo_l, load_s, bus_rdy, nack, ack, mode_s;
	logic [7:0] wr_addr, wr_data, wmask, status;
	logic [2:0] rails;
	logic [2:0][2:0] step_rails;
	logic [2:0][1:0] ss_code;
	logic [2:0][3:0] delay_ms;
	logic [7:0] addrs [6] = '{8'h10, ADDR_HOST_LO, 8'h20, ADDR_MODE, ADDR_VRCTL, ADDR_VEND_HI}; // probe list
	logic [7:0] locked [6] = '{MASK_ALL, MASK_NONE, MASK_NONE, MASK_NONE, VRCTL_OPEN, MASK_NONE}; // secure masks
	int failures = 0;
	int tests_run = 0;
	int seen_load = 0; // load pulses this run
	int n;
	int lim;
	int now = 0; // rising edges since start
	int busy_at = 0; // last rising edge that still saw status not done
	int t0 = 0; // edge count when the enable request was issued
	pmic_power_up_sequencer #(.TICK_CYC(TICK)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.main_input_supply_ok_in(sup_ok), .regulator_enable_pin_in(pin), .devctrl_enable_in(devctrl),
		.wr_valid_in(wr_valid), .wr_addr_in(wr_addr), .wr_data_in(wr_data), .step_rails_in(step_rails),
		.softstart_code_in(ss_code), .step_delay_ms_in(delay_ms), .power_ok_output_out(po),
		.power_ok_output_oe_out(po_oe), .aux_ldo_high_en_out(ldo_h), .aux_ldo_low_en_out(ldo_l),
		.buck_rail_en_out(rails), .load_settings_out(load_s), .bus_ready_out(bus_rdy), .bus_nack_out(nack),
		.wr_ack_out(ack), .wr_bit_mask_out(wmask), .mode_secure_out(mode_s), .status_out(status));
	host_model u_host (.clk_in(clk_in), .ramp_in(ramp), .pin_early_in(pin_early), .pin_req_in(pin_req),
		.supply_ok_out(sup_ok), .pin_out(pin));
	// ***************************************************************
	// clock, pulse counting, compares
	// ***************************************************************
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// counts load pulses where they stand, one cycle each
	always @(negedge clk_in) if (load_s === 1'b1) seen_load++;
	// reads status before the edge updates it, so busy_at is the completion edge
	always @(posedge clk_in) begin
		now++;
		if (status !== STAT_DONE_MASK) busy_at = now;
	end
	task automatic chk_bit(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge clk_in);
	endtask
	// one write, held over one rising edge; answer is combinational
	// an idle cycle follows so back-to-back calls never re-raise valid at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e_ack, input logic [7:0] e_mask);
		wr_valid = 1'b1;
		wr_addr = a;
		wr_data = d;
		#1;
		chk_bit("wr_ack", e_ack, ack);
		if (e_ack) chk_byte("wr_mask", e_mask, wmask);
		@(negedge clk_in);
		wr_valid = 1'b0;
		cyc(1);
	endtask
	// timeout in ms: margin plus worst soft-start and delay of used steps
	function automatic int exp_ms();
		int ms;
		int ss;
		ms = 5;
		for (int s = 0; s < 3; s++) begin
			ss = 0;
			for (int r = 0; r < 3; r++) if (step_rails[s][r] && (1 << ss_code[r]) > ss) ss = 1 << ss_code[r];
			if (step_rails[s] != 3'h0) ms += ss + delay_ms[s];
		end
		return ms;
	endfunction
	// ***************************************************************
	// runs: 0 pin early, 1 write 0x32, 2 common command, 3 late pin
	// ***************************************************************
	initial begin
		{rst_b_in, devctrl, wr_valid, ramp, pin_early, pin_req} = 6'h00;
		{wr_addr, wr_data, step_rails, ss_code, delay_ms} = '0;
		void'($urandom(33803));
		for (int i = 0; i < 4; i++) begin
			rst_b_in = 1'b0;
			ramp <= 1'b0;
			pin_req <= 1'b0;
			pin_early <= (i == 0);
			step_rails = 9'($urandom);
			ss_code = 6'($urandom);
			delay_ms = 12'($urandom);
			cyc(4);
			rst_b_in = 1'b1;
			seen_load = 0;
			cyc(20);
			chk_bit("mode_after_reset", 1'b0, mode_s);
			chk_bit("oe_no_supply", 1'b0, po_oe);
			chk_bit("ldo_no_supply", 1'b0, ldo_h);
			// non-blocking so the host model always sees it one falling edge later
			ramp <= 1'b1;
			t0 = now;
			cyc(6);
			chk_bit("oe_supply", 1'b1, po_oe);
			chk_bit("pok_level", 1'b0, po);
			chk_bit("ldo_high", 1'b1, ldo_h);
			chk_bit("ldo_low", 1'b1, ldo_l);
			cyc(3984);
			chk_bit("bus_early", 1'b0, bus_rdy);
			for (n = 0; n < 40 && bus_rdy !== 1'b1; n++) cyc(1);
			chk_bit("bus_ready", 1'b1, bus_rdy);
			if (bus_rdy !== 1'b1) give_verdict();
			lim = exp_ms() * TICK + 30;
			if (i != 0) begin
				wr(ADDR_MODE, 8'h04, 1'b1, MASK_ALL);
				chk_bit("mode_set", 1'b1, mode_s);
			end
			if (i != 0) t0 = now;
			if (i == 1) wr(ADDR_VRCTL, 8'h80, 1'b1, MASK_ALL);
			if (i == 2) devctrl = 1'b1;
			if (i == 3) pin_req <= 1'b1;
			cyc(1);
			devctrl = 1'b0;
			cyc(4);
			if (i != 0) wr(8'h10, 8'h00, 1'b0, MASK_NONE);
			for (n = 6; n < lim && status !== STAT_DONE_MASK; n++) cyc(1);
			chk_bit("done_in_time", 1'b1, n < lim && busy_at - t0 < lim);
			if (n >= lim) give_verdict();
			chk_bit("not_too_soon", 1'b1, busy_at - t0 + 8 >= (exp_ms() - 11) * TICK);
			chk_byte("status", STAT_DONE_MASK, status);
			chk_bit("oe_released", 1'b0, po_oe);
			chk_byte("rails", step_rails[0] | step_rails[1] | step_rails[2], {5'h00, rails});
			chk_bit("load_once", 1'b1, seen_load == 1);
			chk_bit("nack_done", 1'b0, nack);
			for (int k = 0; k < 5 + (i != 0); k++) wr(addrs[k], 8'h80, 1'b1, (i != 0) ? locked[k] : MASK_ALL);
			chk_bit("mode_kept", i != 0, mode_s);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
